// ===== verilog/sdcb_pkg.sv
// package for the sdram clock-enable and bank state logic
// assumes one clock domain, pins already sampled on the rising edge
package sdcb_pkg;

  // recovery time after self-refresh exit, in ns, and its cycle count at 125 MHz
  localparam int CLK_PERIOD_NS   = 8;
  localparam int RECOVERY_NS     = 80;
  localparam int RECOVERY_CYCLES = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOV_CNT_W     = 4;

  // address bit positions
  localparam int BANK_SEL_BIT_POS  = 11;
  localparam int AUTOCLOSE_BIT_POS = 10;
  localparam int ADDR_W            = 12;

  typedef enum logic [5:0] {
    BANK_IDLE        = 6'h01,
    BANK_ACTIVE      = 6'h02,
    BANK_READ        = 6'h04,
    BANK_WRITE       = 6'h08,
    BANK_READ_CLOSE  = 6'h10,
    BANK_WRITE_CLOSE = 6'h20
  } sdcb_bank_t;

  typedef enum logic [4:0] {
    MODE_NORMAL   = 5'h01,
    MODE_SELFREF  = 5'h02,
    MODE_RECOVERY = 5'h04,
    MODE_PWRDOWN  = 5'h08,
    MODE_SUSPEND  = 5'h10
  } sdcb_mode_t;

  typedef enum logic [3:0] {
    CMD_NOP            = 4'h0,
    CMD_DESELECT       = 4'h1,
    CMD_BURST_STOP     = 4'h2,
    CMD_READ           = 4'h3,
    CMD_WRITE          = 4'h4,
    CMD_ROW_OPEN       = 4'h5,
    CMD_BANK_CLOSE     = 4'h6,
    CMD_REFRESH        = 4'h7,
    CMD_MODE_LOAD      = 4'h8
  } sdcb_cmd_t;

  typedef struct packed {
    logic              clkEn;
    logic              chipSelN;
    logic              rowStrobeN;
    logic              colStrobeN;
    logic              writeEnN;
    logic [ADDR_W-1:0] addr;
  } sdcb_pins_t;

  // pin levels assumed while the synchroniser is in reset: clock-enable high, chip deselected
  localparam sdcb_pins_t PINS_IDLE = '{
    clkEn:      1'b1,
    chipSelN:   1'b1,
    rowStrobeN: 1'b1,
    colStrobeN: 1'b1,
    writeEnN:   1'b1,
    addr:       '0
  };

endpackage : sdcb_pkg

// ===== verilog/sdcb_state_logic.sv
// sdram clock-enable mode and two-bank state tracking
// assumes command pins arrive from outside and are double-synchronised here
//
// Notes on behaviour
// - self-refresh exit goes recovery, then normal
// - clock-enable rise resumes inputs; setup before commands
// - both idle, clock-enable fall with refresh enters self-refresh
// - both idle, clock-enable low: power-down
// - recovery, clock-enable fall with nop: power-down
// - busy bank, clock-enable fall: suspend next cycle
// - suspend holds state until clock-enable high
// - idle command decode by strobe pins
// - bank bit selects bank; autoclose bit variant
// - close with autoclose bit closes both banks
// - each bank tracks six states
`timescale 1ns/1ns
module sdcb_state_logic (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire sdcb_pkg::sdcb_pins_t pinsIn,
  output sdcb_pkg::sdcb_mode_t      mode,
  output sdcb_pkg::sdcb_bank_t      bank0State,
  output sdcb_pkg::sdcb_bank_t      bank1State,
  output logic                      illegalCmd
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchroniser
  sdcb_pkg::sdcb_pins_t syncA_q;
  sdcb_pkg::sdcb_pins_t syncB_q;
  logic                 clkEnPrev_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      syncA_q     <= sdcb_pkg::PINS_IDLE;
      syncB_q     <= sdcb_pkg::PINS_IDLE;
      clkEnPrev_q <= sdcb_pkg::PINS_IDLE.clkEn;
    end else begin
      syncA_q     <= pinsIn;
      syncB_q     <= syncA_q;
      clkEnPrev_q <= syncB_q.clkEn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decode
  sdcb_pkg::sdcb_cmd_t cmd;
  logic                bankSel;
  logic                autoClose;
  logic                ckeN;
  logic                ckeP;
  logic                nopLike;

  assign bankSel   = syncB_q.addr[sdcb_pkg::BANK_SEL_BIT_POS];
  assign autoClose = syncB_q.addr[sdcb_pkg::AUTOCLOSE_BIT_POS];
  assign ckeN      = syncB_q.clkEn;
  assign ckeP      = clkEnPrev_q;
  assign nopLike   = syncB_q.chipSelN | (syncB_q.rowStrobeN & syncB_q.colStrobeN);

  always_comb begin
    cmd = sdcb_pkg::CMD_NOP;
    if (syncB_q.chipSelN) begin
      cmd = sdcb_pkg::CMD_DESELECT;
    end else begin
      case ({syncB_q.rowStrobeN, syncB_q.colStrobeN, syncB_q.writeEnN})
        3'h7:    cmd = sdcb_pkg::CMD_NOP;
        3'h6:    cmd = sdcb_pkg::CMD_BURST_STOP;
        3'h5:    cmd = sdcb_pkg::CMD_READ;
        3'h4:    cmd = sdcb_pkg::CMD_WRITE;
        3'h3:    cmd = sdcb_pkg::CMD_ROW_OPEN;
        3'h2:    cmd = sdcb_pkg::CMD_BANK_CLOSE;
        3'h1:    cmd = sdcb_pkg::CMD_REFRESH;
        3'h0:    cmd = sdcb_pkg::CMD_MODE_LOAD;
        default: cmd = sdcb_pkg::CMD_NOP;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode state machine
  sdcb_pkg::sdcb_mode_t                mode_q;
  sdcb_pkg::sdcb_mode_t                mode_d;
  logic [sdcb_pkg::RECOV_CNT_W-1:0]    recov_q;
  logic [sdcb_pkg::RECOV_CNT_W-1:0]    recov_d;
  logic                                illegal_q;
  logic                                illegal_d;
  logic                                bothIdle;
  logic                                cmdEnable;

  assign bothIdle = (bank0State == sdcb_pkg::BANK_IDLE) && (bank1State == sdcb_pkg::BANK_IDLE);

  always_comb begin
    mode_d    = mode_q;
    recov_d   = recov_q;
    illegal_d = 1'b0;
    cmdEnable = 1'b0;
    case (mode_q)
      sdcb_pkg::MODE_NORMAL: begin
        if (ckeP && ckeN) begin
          cmdEnable = 1'b1;
        end else if (ckeP && !ckeN) begin
          if (bothIdle) begin
            if (cmd == sdcb_pkg::CMD_REFRESH) begin
              mode_d = sdcb_pkg::MODE_SELFREF;
            end else begin
              mode_d = sdcb_pkg::MODE_PWRDOWN;
            end
          end else begin
            cmdEnable = 1'b1;
            mode_d    = sdcb_pkg::MODE_SUSPEND;
          end
        end else if (!ckeP && !ckeN && bothIdle) begin
          mode_d = sdcb_pkg::MODE_PWRDOWN;
        end
      end
      sdcb_pkg::MODE_SELFREF: begin
        illegal_d = ckeP;
        if (!ckeP && ckeN) begin
          illegal_d = !nopLike;
          mode_d    = sdcb_pkg::MODE_RECOVERY;
          recov_d   = sdcb_pkg::RECOVERY_CYCLES[sdcb_pkg::RECOV_CNT_W-1:0];
        end
      end
      sdcb_pkg::MODE_RECOVERY: begin
        if (ckeP) begin
          illegal_d = !nopLike;
          if (!ckeN) begin
            illegal_d = !nopLike;
            mode_d    = sdcb_pkg::MODE_PWRDOWN;
          end else if (recov_q <= 4'h1) begin
            mode_d  = sdcb_pkg::MODE_NORMAL;
            recov_d = '0;
          end else begin
            recov_d = recov_q - 4'h1;
          end
        end
      end
      sdcb_pkg::MODE_PWRDOWN: begin
        illegal_d = ckeP;
        if (ckeN) begin
          mode_d = sdcb_pkg::MODE_NORMAL;
        end
      end
      sdcb_pkg::MODE_SUSPEND: begin
        if (ckeP) begin
          mode_d = sdcb_pkg::MODE_NORMAL;
        end
      end
      default: mode_d = sdcb_pkg::MODE_NORMAL;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_q    <= sdcb_pkg::MODE_NORMAL;
      recov_q   <= '0;
      illegal_q <= 1'b0;
    end else begin
      mode_q    <= mode_d;
      recov_q   <= recov_d;
      illegal_q <= illegal_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-bank state, one generate loop
  sdcb_pkg::sdcb_bank_t bank_q [2];
  sdcb_pkg::sdcb_bank_t bank_d [2];

  for (genvar b = 0; b < 2; b++) begin : gBank
    logic hit;
    logic peerOpen;
    assign hit      = (bankSel == 1'(b));
    assign peerOpen = (bank_q[1 - b] != sdcb_pkg::BANK_IDLE);

    always_comb begin
      bank_d[b] = bank_q[b];
      if (cmdEnable) begin
        case (cmd)
          sdcb_pkg::CMD_ROW_OPEN: begin
            if (hit) begin
              bank_d[b] = sdcb_pkg::BANK_ACTIVE;
            end
          end
          sdcb_pkg::CMD_READ: begin
            if (hit && bank_q[b] != sdcb_pkg::BANK_IDLE) begin
              bank_d[b] = autoClose ? sdcb_pkg::BANK_READ_CLOSE : sdcb_pkg::BANK_READ;
            end else if (!hit && peerOpen && bank_q[b] != sdcb_pkg::BANK_IDLE) begin
              bank_d[b] = sdcb_pkg::BANK_ACTIVE;
            end
          end
          sdcb_pkg::CMD_WRITE: begin
            if (hit && bank_q[b] != sdcb_pkg::BANK_IDLE) begin
              bank_d[b] = autoClose ? sdcb_pkg::BANK_WRITE_CLOSE : sdcb_pkg::BANK_WRITE;
            end else if (!hit && peerOpen && bank_q[b] != sdcb_pkg::BANK_IDLE) begin
              bank_d[b] = sdcb_pkg::BANK_ACTIVE;
            end
          end
          sdcb_pkg::CMD_BANK_CLOSE: begin
            if (autoClose || hit) begin
              bank_d[b] = sdcb_pkg::BANK_IDLE;
            end
          end
          sdcb_pkg::CMD_BURST_STOP: begin
            if (bank_q[b] == sdcb_pkg::BANK_READ || bank_q[b] == sdcb_pkg::BANK_WRITE) begin
              bank_d[b] = sdcb_pkg::BANK_ACTIVE;
            end
          end
          default: bank_d[b] = bank_q[b];
        endcase
      end
    end

    always_ff @(posedge mclk) begin
      if (rst) begin
        bank_q[b] <= sdcb_pkg::BANK_IDLE;
      end else begin
        bank_q[b] <= bank_d[b];
      end
    end
  end

  assign mode       = mode_q;
  assign bank0State = bank_q[0];
  assign bank1State = bank_q[1];
  assign illegalCmd = illegal_q;

endmodule : sdcb_state_logic

// ===== sim/sdcb_ctl_model.sv
// controller model driving the command pins
// assumes the bench calls send; pins change on the falling edge
`timescale 1ns/1ns
module sdcb_ctl_model (
  input  wire logic            mclk,
  output sdcb_pkg::sdcb_pins_t pins
);
  initial pins = {1'b1, 4'h7, 12'h000};
  ////////////////////////
  // one command cycle, then no-op at the same clock-enable
  task send(input logic ck, input logic [3:0] c, input logic [11:0] a);
    @(negedge mclk) pins <= {ck, c, a};
    @(negedge mclk) pins <= {ck, 4'h7, a};
    repeat (3) @(negedge mclk);
  endtask : send
endmodule : sdcb_ctl_model

// ===== sim/sdcb_props.sv
// checker for the state logic ports
// assumes pins act three edges after they are driven
`timescale 1ns/1ns
module sdcb_props (
  input wire logic                 mclk,
  input wire logic                 rst,
  input wire sdcb_pkg::sdcb_pins_t pinsIn,
  input wire sdcb_pkg::sdcb_mode_t mode,
  input wire sdcb_pkg::sdcb_bank_t bank0State,
  input wire sdcb_pkg::sdcb_bank_t bank1State,
  input wire logic                 illegalCmd
);
  sdcb_pkg::sdcb_pins_t p1, p2, p3;
  always_ff @(posedge mclk) begin
    p1 <= pinsIn;
    p2 <= p1;
    p3 <= p2;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////
  rst_values_a: assert property (disable iff (1'b0) rst |=> mode == sdcb_pkg::MODE_NORMAL
    && bank0State == sdcb_pkg::BANK_IDLE && bank1State == bank0State && !illegalCmd)
    else $error("reset state wrong");
  sr_hold_a: assert property (mode == sdcb_pkg::MODE_SELFREF && !p2.clkEn |=>
    mode == sdcb_pkg::MODE_SELFREF) else $error("self-refresh left");
  pd_hold_a: assert property (mode == sdcb_pkg::MODE_PWRDOWN && !p2.clkEn |=>
    mode == sdcb_pkg::MODE_PWRDOWN) else $error("power-down left");
  pd_exit_a: assert property (mode == sdcb_pkg::MODE_PWRDOWN && p2.clkEn && !p3.clkEn |=>
    mode == sdcb_pkg::MODE_NORMAL) else $error("power-down exit missed");
  susp_entry_a: assert property (mode == sdcb_pkg::MODE_NORMAL && p3.clkEn && !p2.clkEn
    && (bank0State != sdcb_pkg::BANK_IDLE || bank1State != sdcb_pkg::BANK_IDLE)
    |=> mode == sdcb_pkg::MODE_SUSPEND)
    else $error("suspend entry missed");
  susp_hold_a: assert property (mode == sdcb_pkg::MODE_SUSPEND && !p2.clkEn && !p3.clkEn |=>
    mode == sdcb_pkg::MODE_SUSPEND && $stable(bank0State) && $stable(bank1State))
    else $error("suspend did not hold");
  recov_bad_a: assert property (mode == sdcb_pkg::MODE_RECOVERY && p2.clkEn && p3.clkEn
    && !p2.chipSelN && !(p2.rowStrobeN && p2.colStrobeN) |=> illegalCmd)
    else $error("recovery command not flagged");
  recov_pd_a: assert property (mode == sdcb_pkg::MODE_RECOVERY && p3.clkEn && !p2.clkEn
    && (p2.chipSelN || p2.rowStrobeN && p2.colStrobeN) |-> ##[1:2] mode == sdcb_pkg::MODE_PWRDOWN)
    else $error("recovery to power-down missed");
  cover property (mode == sdcb_pkg::MODE_SELFREF);
  cover property (mode == sdcb_pkg::MODE_SUSPEND);
  cover property (illegalCmd);
endmodule : sdcb_props
bind sdcb_state_logic sdcb_props u_props (.mclk(mclk), .rst(rst), .pinsIn(pinsIn),
  .mode(mode), .bank0State(bank0State), .bank1State(bank1State), .illegalCmd(illegalCmd));

// ===== sim/tb_top.sv
// bench for the state logic
// assumes the controller model drives every command pin
`timescale 1ns/1ns
module tb_top;
  logic                 mclk = 1'b0;
  logic                 rst  = 1'b1;
  sdcb_pkg::sdcb_pins_t pins;
  sdcb_pkg::sdcb_mode_t mode;
  sdcb_pkg::sdcb_bank_t b0;
  sdcb_pkg::sdcb_bank_t b1;
  logic                 illegalCmd;
  int                   n_fail = 0;
  int                   checks = 0;
  int                   nIll = 0;
  int                   n0;
  always #4 mclk = ~mclk;
  always @(negedge mclk) if (illegalCmd === 1'b1) nIll++;
  sdcb_ctl_model u_ctl (.mclk(mclk), .pins(pins));
  sdcb_state_logic u_dut (.mclk(mclk), .rst(rst), .pinsIn(pins), .mode(mode),
    .bank0State(b0), .bank1State(b1), .illegalCmd(illegalCmd));
  ////////////////////////
  task chk(input string nm, input logic [5:0] e, input logic [5:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task st(input logic [5:0] m, input logic [5:0] e0, input logic [5:0] e1);
    chk("mode", m, 6'(mode));
    chk("bank0", e0, b0);
    chk("bank1", e1, b1);
  endtask : st
  task t_banks;
    st(6'h01, 6'h01, 6'h01);
    u_ctl.send(1, 4'hB, 12'h800);
    st(6'h01, 6'h01, 6'h01);
    u_ctl.send(1, 4'h0, 12'h000);
    u_ctl.send(1, 4'h1, 12'h000);
    st(6'h01, 6'h01, 6'h01);
    u_ctl.send(1, 4'h3, 12'h800);
    st(6'h01, 6'h01, 6'h02);
    u_ctl.send(1, 4'h5, 12'hC00);
    st(6'h01, 6'h01, 6'h10);
    u_ctl.send(1, 4'h2, 12'h400);
    st(6'h01, 6'h01, 6'h01);
    u_ctl.send(1, 4'h3, 12'h000);
    u_ctl.send(1, 4'h4, 12'h000);
    st(6'h01, 6'h08, 6'h01);
    u_ctl.send(1, 4'h6, 12'h000);
    st(6'h01, 6'h02, 6'h01);
    u_ctl.send(1, 4'h3, 12'h800);
    u_ctl.send(1, 4'h2, 12'h000);
    st(6'h01, 6'h01, 6'h02);
    u_ctl.send(1, 4'h4, 12'hC00);
    st(6'h01, 6'h01, 6'h20);
    u_ctl.send(1, 4'h3, 12'h000);
    u_ctl.send(1, 4'h5, 12'h000);
    st(6'h01, 6'h04, 6'h02);
    u_ctl.send(1, 4'h2, 12'h000);
    st(6'h01, 6'h01, 6'h02);
  endtask : t_banks
  task t_suspend;
    u_ctl.send(0, 4'h7, 12'h000);
    st(6'h10, 6'h01, 6'h02);
    u_ctl.send(0, 4'h3, 12'h000);
    st(6'h10, 6'h01, 6'h02);
    u_ctl.send(1, 4'h7, 12'h000);
    st(6'h01, 6'h01, 6'h02);
    u_ctl.send(1, 4'h2, 12'h400);
    st(6'h01, 6'h01, 6'h01);
  endtask : t_suspend
  task t_low;
    u_ctl.send(0, 4'h1, 12'h000);
    st(6'h02, 6'h01, 6'h01);
    u_ctl.send(1, 4'h7, 12'h000);
    st(6'h04, 6'h01, 6'h01);
    n0 = nIll;
    u_ctl.send(1, 4'h3, 12'h800);
    chk("illegal", 6'h01, 6'(nIll - n0));
    repeat (12) @(negedge mclk);
    st(6'h01, 6'h01, 6'h01);
    u_ctl.send(0, 4'h1, 12'h000);
    u_ctl.send(1, 4'h7, 12'h000);
    u_ctl.send(0, 4'h7, 12'h000);
    st(6'h08, 6'h01, 6'h01);
    u_ctl.send(1, 4'h7, 12'h000);
    st(6'h01, 6'h01, 6'h01);
    u_ctl.send(0, 4'h7, 12'h000);
    st(6'h08, 6'h01, 6'h01);
    chk("illegal total", 6'h01, 6'(nIll));
  endtask : t_low
  task stop_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test
  initial begin
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    t_banks;
    t_suspend;
    t_low;
    stop_test;
  end
  initial begin
    #20000;
    n_fail++;
    stop_test;
  end
endmodule : tb_top
